/* File: dv/rxp_link_model.sv */
// Event source standing in for the serial bus side of the receive path.
// Assumes callers wait on rising edges of clk_i.
`timescale 1ns/1ps
`default_nettype none
module rxp_link_model (
    // Clock
    input wire logic clk_i,
    // Events toward the registers
    output var rxp_pkg::rxp_pkt_t pkt_o,
    output var rxp_pkg::rxp_stream_t strm_a_o,
    output var rxp_pkg::rxp_stream_t strm_b_o
);
    initial begin
        pkt_o = '0;
        strm_a_o = '0;
        strm_b_o = '0;
    end
    // Stale qualifiers except is_void are inverted, not held, so a late sample shows up
    task send(input logic [12:0] p, input logic [8:0] a, input logic [8:0] b);
        @(posedge clk_i);
        pkt_o <= rxp_pkg::rxp_pkt_t'(p);
        strm_a_o <= rxp_pkg::rxp_stream_t'(a);
        strm_b_o <= rxp_pkg::rxp_stream_t'(b);
        @(posedge clk_i);
        pkt_o <= rxp_pkg::rxp_pkt_t'(~p & 13'h0C07);
        strm_a_o <= rxp_pkg::rxp_stream_t'((~a & 9'h0F8) | (a & 9'h001));
        strm_b_o <= rxp_pkg::rxp_stream_t'((~b & 9'h0F8) | (b & 9'h001));
    endtask : send
endmodule : rxp_link_model
`default_nettype wire

/* File: dv/rxp_regs_chk.sv */
// Checker for the receive path register block, bound to its ports.
// Assumes word accesses on the bus and one-cycle event pulses.
`timescale 1ns/1ps
`default_nettype none
module rxp_regs_chk (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Events and controls
    input wire rxp_pkg::rxp_pkt_t pkt_i,
    input wire rxp_pkg::rxp_stream_t strm_a_i,
    input wire logic cnt_clr_a_o,
    input wire logic cnt_clr_b_o,
    input wire logic drop_a_o,
    input wire logic crc_flush_o,
    input wire logic [3:0] ack_code_o,
    input wire logic pkt_abort_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_req(w, a);
        hsel_i && hready_i && htrans_i[1] && hwrite_i == w && haddr_i == a;
    endsequence
    sequence s_clr_b;
        s_req(1'b1, rxp_pkg::CTRL_ADDR) ##1 hwdata_i[9];
    endsequence
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or not okay");
    // Read data is settled one edge after the address is taken and then held
    a_ctrl_rsvd: assert property (s_req(1'b0, rxp_pkg::CTRL_ADDR) |-> ##2
        hrdata_o[31:8] == 24'h0 && hrdata_o[4:3] == 2'h0)
        else $error("control reserved bits not zero");
    a_stat_rsvd: assert property (s_req(1'b0, rxp_pkg::STAT_ADDR) |-> ##2
        hrdata_o[31:16] == 16'h0 && hrdata_o[9:1] == 9'h0)
        else $error("status reserved bits not zero");
    a_hole_zero: assert property (s_req(1'b0, 12'h350) |-> ##2
        hrdata_o == 32'h0) else $error("unmapped read not zero");
    a_busy_ack: assert property (
        pkt_i.start && pkt_i.is_async && pkt_i.engine_busy
        |=> ack_code_o == rxp_pkg::ACK_BUSY_X) else $error("busy ack missing");
    a_abort_cause: assert property (
        pkt_i.no_dest || pkt_i.bad_tcode |=> pkt_abort_o)
        else $error("abort missing");
    a_crc_abort: assert property (
        pkt_i.crc_err && crc_flush_o |=> pkt_abort_o)
        else $error("crc abort missing");
    a_abort_reason: assert property (pkt_abort_o |->
        $past(pkt_i.no_dest) || $past(pkt_i.bad_tcode) ||
        $past(pkt_i.crc_err))
        else $error("abort without cause");
    a_clr_b_write: assert property (s_clr_b |-> ##[1:2] cnt_clr_b_o)
        else $error("counter clear b missing");
    a_clr_a_once: assert property (cnt_clr_a_o |=> !cnt_clr_a_o)
        else $error("counter clear a not a pulse");
    a_void_keep: assert property (!$past(strm_a_i.is_void) |-> !drop_a_o)
        else $error("drop without void packet");
    a_flush_reset: assert property ($rose(nrst_i) |-> crc_flush_o)
        else $error("crc flush not set after reset");
endmodule : rxp_regs_chk
`default_nettype wire

/* File: dv/test_rxp_regs.sv */
// Self-checking bench for the receive path registers.
// Assumes the bus slave answers with hreadyout fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module test_rxp_regs;
    localparam int NBUF = 8;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, clr_a, clr_b, drop_a, drop_b;
    logic flush, sid_full, abort, irq;
    logic [3:0] ack;
    rxp_pkg::rxp_pkt_t pkt;
    rxp_pkg::rxp_stream_t sa, sb;
    logic [7:0] vid_a = 8'h00;
    logic [7:0] vid_b = 8'h00;
    int fail_count = 0;
    int checked = 0;
    int clr_a_n = 0;
    int clr_b_n = 0;
    logic [31:0] rdv;
    // Event inputs beside the flag word they should leave behind
    logic [62:0] rows [17] = '{
        {13'h0017, 9'h000, 9'h000, 32'h0080_0000},
        {13'h0010, 9'h000, 9'h000, 32'h0001_0000},
        {13'h000D, 9'h000, 9'h000, 32'h2000_0000},
        {13'h0202, 9'h000, 9'h000, 32'h0400_0020},
        {13'h0101, 9'h000, 9'h000, 32'h0200_0010},
        {13'h0084, 9'h000, 9'h000, 32'h1000_0008},
        {13'h0040, 9'h000, 9'h000, 32'h0000_0002},
        {13'h0020, 9'h000, 9'h000, 32'h0000_0001},
        {13'h1C00, 9'h000, 9'h000, 32'h0000_0044},
        {13'h0000, 9'h180, 9'h000, 32'h0000_4000},
        {13'h0000, 9'h000, 9'h180, 32'h0000_8000},
        {13'h0000, 9'h1A0, 9'h000, 32'h0000_1000},
        {13'h0000, 9'h000, 9'h1A0, 32'h0000_2000},
        {13'h0000, 9'h004, 9'h000, 32'h0000_0400},
        {13'h0000, 9'h000, 9'h004, 32'h0000_0800},
        {13'h0000, 9'h002, 9'h000, 32'h0000_0100},
        {13'h0000, 9'h000, 9'h002, 32'h0000_0200}};
    logic [7:0] ctl_v [4] = '{8'h22, 8'h23, 8'h21, 8'h20};
    logic [3:0] ack_v [4] = '{rxp_pkg::ACK_TARDY, rxp_pkg::ACK_BUSY_X,
        rxp_pkg::ACK_BUSY_X, rxp_pkg::ACK_NONE};
    rxp_regs #(.NBUF(NBUF)) rxp_regs_inst (.ref_clk_i(ref_clk),
        .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
        .hresp_o(hresp), .pkt_i(pkt), .strm_a_i(sa), .strm_b_i(sb),
        .buf_vid_a_i(vid_a), .buf_vid_b_i(vid_b), .cnt_clr_a_o(clr_a),
        .cnt_clr_b_o(clr_b), .drop_a_o(drop_a), .drop_b_o(drop_b),
        .crc_flush_o(flush), .sid_full_o(sid_full), .ack_code_o(ack),
        .pkt_abort_o(abort), .summary_irq_o(irq));
    rxp_link_model rxp_link_model_inst (.clk_i(ref_clk), .pkt_o(pkt),
        .strm_a_o(sa), .strm_b_o(sb));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (clr_a === 1'b1) clr_a_n++;
        if (clr_b === 1'b1) clr_b_n++;
    end
    task stop_test;
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        r = hrdata;
    endtask : bus
    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rdv);
    endtask : wr
    task rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, rdv);
        chk(rdv, e);
    endtask : rdc
    task tick;
        @(posedge ref_clk);
        #1;
    endtask : tick
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rdc(rxp_pkg::CTRL_ADDR, 32'h20);
        rdc(rxp_pkg::STAT_ADDR, 32'h0);
        rdc(rxp_pkg::FLAG_ADDR, 32'h0);
        rdc(rxp_pkg::MASK_ADDR, 32'h0);
        chk({31'h0, flush}, 32'h1);
        wr(rxp_pkg::MASK_ADDR, 32'hFFFF_FF7F);
        for (int i = 0; i < 17; i++) begin
            rxp_link_model_inst.send(rows[i][62:50], rows[i][49:41],
                rows[i][40:32]);
            #1;
            chk({31'h0, irq}, 32'h1);
            rdc(rxp_pkg::FLAG_ADDR, rows[i][31:0]);
            rdc(rxp_pkg::FLAG_ADDR, 32'h0);
        end
        rdc(rxp_pkg::STAT_ADDR, 32'h5C00);
        vid_a <= 8'h05;
        rdc(rxp_pkg::STAT_ADDR, 32'h5C01);
        vid_a <= 8'h01;
        vid_b <= 8'h30;
        rdc(rxp_pkg::STAT_ADDR, 32'h5C01);
        vid_b <= 8'h10;
        rdc(rxp_pkg::STAT_ADDR, 32'h5C00);
        for (int k = 0; k < 4; k++) begin
            wr(rxp_pkg::CTRL_ADDR, {24'h0, ctl_v[k]});
            rxp_link_model_inst.send(13'h1400, 9'h000, 9'h000);
            #1;
            chk({28'h0, ack}, {28'h0, ack_v[k]});
        end
        rdc(rxp_pkg::FLAG_ADDR, 32'h40);
        wr(rxp_pkg::CTRL_ADDR, 32'h0);
        rxp_link_model_inst.send(13'h0203, 9'h000, 9'h000);
        #1;
        chk({31'h0, abort}, 32'h0);
        chk({31'h0, flush}, 32'h0);
        rdc(rxp_pkg::FLAG_ADDR, 32'h20);
        wr(rxp_pkg::CTRL_ADDR, 32'h24);
        tick();
        chk({31'h0, sid_full}, 32'h1);
        rxp_link_model_inst.send(13'h0000, 9'h001, 9'h001);
        tick();
        chk({30'h0, drop_b, drop_a}, 32'h3);
        wr(rxp_pkg::CTRL_ADDR, 32'hE4);
        tick();
        chk({30'h0, drop_b, drop_a}, 32'h0);
        rdc(rxp_pkg::CTRL_ADDR, 32'hE4);
        rxp_link_model_inst.send(13'h0000, 9'h000, 9'h000);
        wr(rxp_pkg::CTRL_ADDR, 32'h320);
        repeat (3) tick();
        chk(clr_a_n + clr_b_n * 16, 32'h11);
        rdc(rxp_pkg::CTRL_ADDR, 32'h20);
        wr(rxp_pkg::MASK_ADDR, 32'h0);
        rxp_link_model_inst.send(13'h0040, 9'h000, 9'h000);
        #1;
        chk({31'h0, irq}, 32'h0);
        wr(rxp_pkg::MASK_ADDR, 32'h2);
        tick();
        chk({31'h0, irq}, 32'h1);
        rdc(rxp_pkg::FLAG_ADDR, 32'h2);
        tick();
        chk({31'h0, irq}, 32'h0);
        wr(12'h350, 32'hFFFF_FFFF);
        rdc(12'h350, 32'h0);
        stop_test();
    end
    // Whole run is well under a thousand cycles; this only cuts a hang
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end
endmodule : test_rxp_regs
bind rxp_regs rxp_regs_chk rxp_regs_chk_inst (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .pkt_i(pkt_i), .strm_a_i(strm_a_i),
    .cnt_clr_a_o(cnt_clr_a_o), .cnt_clr_b_o(cnt_clr_b_o),
    .drop_a_o(drop_a_o), .crc_flush_o(crc_flush_o),
    .ack_code_o(ack_code_o), .pkt_abort_o(pkt_abort_o));
`default_nettype wire

/* File: rtl/rxp_pkg.sv */
// Package for the receive path control, status and event flag registers.
// Assumes a single 40 MHz clock domain and an AHB-Lite register bus.
package rxp_pkg;
    // Register byte addresses
    localparam logic [11:0] CTRL_ADDR = 12'h340;
    localparam logic [11:0] STAT_ADDR = 12'h344;
    localparam logic [11:0] FLAG_ADDR = 12'h348;
    localparam logic [11:0] MASK_ADDR = 12'h34C;
    // Control field positions
    localparam int CTRL_CNT_CLR_B = 9;
    localparam int CTRL_CNT_CLR_A = 8;
    localparam int CTRL_VOID_B = 7;
    localparam int CTRL_VOID_A = 6;
    localparam int CTRL_CRC_DROP = 5;
    localparam int CTRL_SID_FULL = 2;
    localparam int CTRL_LATE_ACK = 1;
    localparam int CTRL_BUSY_ACK = 0;
    // Control reset value: payload CRC drop on
    localparam logic [7:0] CTRL_RESET = 8'h20;
    // Writable control bits (bits 7:0 less reserved 4:3)
    localparam logic [7:0] CTRL_WMASK = 8'hE7;
    // Acknowledge codes
    localparam logic [3:0] ACK_TARDY = 4'hB;
    localparam logic [3:0] ACK_BUSY_X = 4'h4;
    localparam logic [3:0] ACK_NONE = 4'h0;
    // Flag positions
    localparam int FLG_ABORT_LSB = 24;
    localparam int FLG_ARRIVE_LSB = 16;
    localparam int FLG_PAR_B = 15;
    localparam int FLG_PAR_A = 14;
    localparam int FLG_CCI_B = 13;
    localparam int FLG_CCI_A = 12;
    localparam int FLG_STEER_B = 11;
    localparam int FLG_STEER_A = 10;
    localparam int FLG_SEQ_B = 9;
    localparam int FLG_SEQ_A = 8;
    localparam int FLG_REJECT = 6;
    localparam int FLG_CRC = 5;
    localparam int FLG_NODEST = 4;
    localparam int FLG_TCODE = 3;
    localparam int FLG_OCCUPIED = 2;
    localparam int FLG_RST_CMD = 1;
    localparam int FLG_SID_DONE = 0;
    localparam logic [31:0] FLG_VALID = 32'hFFFF_FF7F;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    // Per-stream receive events from the data path
    typedef struct packed {
        logic pkt_done;
        logic key_parity;
        logic [1:0] cci_seen;
        logic [1:0] cci_cipher;
        logic steer_err;
        logic seq_err;
        logic is_void;
    } rxp_stream_t;
    // Packet events from the receive engine
    typedef struct packed {
        logic start;
        logic engine_busy;
        logic is_async;
        logic crc_err;
        logic no_dest;
        logic bad_tcode;
        logic rst_cmd;
        logic sid_done;
        logic confirm;
        logic abort;
        logic [2:0] buf_idx;
    } rxp_pkt_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01
    } rxp_bus_st_t;
endpackage : rxp_pkg

/* File: rtl/rxp_regs.sv */
// Receive path control, status and event flag registers with AHB-Lite.
// Assumes events arrive as one-cycle pulses synchronous to ref_clk_i.
//
// Function
// R01: Writing 1 to control bit 9/8 pulses counter B/A clear, self clears.
// R02: Void packets of stream B/A dropped unless bit 7/6 set.
// R03: Bit 5 (reset 1) aborts and flushes packets with payload CRC error.
// R04: Bit 2 set stores both self identification quadlets.
// R05: Bit 1 set acknowledges async packets with tardy code B unless busy.
// R06: Bit 0 set acknowledges async packets with busy code 4, wins.
// R07: Status 15:14 and 13:12 show copy indicator of stream B and A.
// R08: Status 11/10 hold key parity of stream A/B, refreshed per packet.
// R09: Status bit 0 follows duplicate video type A or B buffer selection.
// R10: Flags 31:24 set per buffer when a packet is aborted.
// R11: Flags 23:16 set per buffer when a packet is confirmed.
// R12: Flags 15/14 set when key parity of stream B/A changes.
// R13: Flags 13/12 set when copy indicator differs from cipher setting.
// R14: Flags 11/10 set on header steering fault of stream B/A.
// R15: Flags 9/8 set on video sequence fault of stream B/A.
// R16: Flag 6 set when busy acknowledge was sent.
// R17: Flag 5 set when payload CRC check fails.
// R18: No destination buffer aborts the packet and sets flag 4.
// R19: Illegal transaction code aborts the packet and sets flag 3.
// R20: Reception start while engine busy busies packet, sets flag 2.
// R21: Quadlet write to reset start register sets flag 1.
// R22: Flag 0 set when self identification ends and all confirmed.
// R23: Summary interrupt ors flags gated by their enable bits.
// R24: Flags stay set until read; a read clears the bits returned.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module rxp_regs #(
    parameter int NBUF = 8
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Receive path events
    input wire rxp_pkg::rxp_pkt_t pkt_i,
    input wire rxp_pkg::rxp_stream_t strm_a_i,
    input wire rxp_pkg::rxp_stream_t strm_b_i,
    input wire logic [NBUF-1:0] buf_vid_a_i,
    input wire logic [NBUF-1:0] buf_vid_b_i,
    // Data path controls
    output logic cnt_clr_a_o,
    output logic cnt_clr_b_o,
    output logic drop_a_o,
    output logic drop_b_o,
    output logic crc_flush_o,
    output logic sid_full_o,
    output logic [3:0] ack_code_o,
    output logic pkt_abort_o,
    output logic summary_irq_o
);
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic rst_n;
    logic [7:0] ctrl_ff;
    logic [31:0] flag_ff;
    logic [31:0] mask_ff;
    logic par_a_ff;
    logic par_b_ff;
    logic [1:0] cci_a_ff;
    logic [1:0] cci_b_ff;
    logic conflict_ff;
    rxp_pkg::rxp_bus_st_t st_ff;
    logic wr_ff;
    logic [11:0] addr_ff;
    logic [31:0] nxt_flag;
    logic [31:0] flag_set;
    logic [31:0] rd_clr;
    logic [31:0] rd_data;
    logic addr_ok;
    logic wr_now;
    logic [3:0] nxt_ack;
    logic nxt_abort;
    logic nxt_drop_a;
    logic nxt_drop_b;
    logic nxt_conflict;
    logic bus_go;
    logic bad_size;

    assign rst_n = rst_s2_ff;

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // Bus address phase capture; slave always ready, response OKAY
    assign bus_go = hsel_i && hready_i && htrans_i[1];
    assign bad_size = hsize_i != 3'b010;
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= rxp_pkg::ST_IDLE;
            wr_ff <= 1'b0;
            addr_ff <= 12'h000;
        end else if (hready_i) begin
            st_ff <= bus_go ? rxp_pkg::ST_DATA : rxp_pkg::ST_IDLE;
            wr_ff <= bus_go && hwrite_i && !bad_size;
            addr_ff <= {haddr_i[11:2], 2'b00};
        end
    end
    assign wr_now = (st_ff == rxp_pkg::ST_DATA) && wr_ff;

    // Read mux; unmapped addresses read zero
    always_comb begin
        addr_ok = 1'b1;
        rd_data = 32'h0000_0000;
        case (haddr_i[11:2])
            rxp_pkg::CTRL_ADDR[11:2]: rd_data = {24'h00_0000,
                ctrl_ff & rxp_pkg::CTRL_WMASK};
            rxp_pkg::STAT_ADDR[11:2]: rd_data = {16'h0000, cci_b_ff, // R07
                cci_a_ff, par_a_ff, par_b_ff, 9'h000, conflict_ff}; // R08
            rxp_pkg::FLAG_ADDR[11:2]: rd_data = flag_ff;
            rxp_pkg::MASK_ADDR[11:2]: rd_data = mask_ff;
            default: addr_ok = 1'b0;
        endcase
    end

    // Read data registered in the data phase
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_o <= 32'h0000_0000;
        end else if (bus_go && !hwrite_i) begin
            hrdata_o <= addr_ok ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // Control register; clear bits self clear after one cycle
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= rxp_pkg::CTRL_RESET;
        end else if (wr_now && addr_ff == rxp_pkg::CTRL_ADDR) begin
            ctrl_ff <= hwdata_i[7:0] & rxp_pkg::CTRL_WMASK;
        end else begin
            ctrl_ff <= ctrl_ff & rxp_pkg::CTRL_WMASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cnt_clr_a_o <= 1'b0;
            cnt_clr_b_o <= 1'b0;
        end else begin
            cnt_clr_b_o <= wr_now && addr_ff == rxp_pkg::CTRL_ADDR &&
                hwdata_i[rxp_pkg::CTRL_CNT_CLR_B]; // R01
            cnt_clr_a_o <= wr_now && addr_ff == rxp_pkg::CTRL_ADDR &&
                hwdata_i[rxp_pkg::CTRL_CNT_CLR_A]; // R01
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= rxp_pkg::MASK_RESET;
        end else if (wr_now && addr_ff == rxp_pkg::MASK_ADDR) begin
            mask_ff <= hwdata_i & rxp_pkg::FLG_VALID;
        end
    end

    // Acknowledge and drop decisions for each packet
    always_comb begin
        nxt_ack = rxp_pkg::ACK_NONE;
        if (pkt_i.start && pkt_i.is_async) begin
            if (ctrl_ff[rxp_pkg::CTRL_BUSY_ACK] || pkt_i.engine_busy) begin
                nxt_ack = rxp_pkg::ACK_BUSY_X; // R06 R20
            end else if (ctrl_ff[rxp_pkg::CTRL_LATE_ACK]) begin
                nxt_ack = rxp_pkg::ACK_TARDY; // R05
            end
        end
        nxt_drop_a = strm_a_i.is_void && !ctrl_ff[rxp_pkg::CTRL_VOID_A]; // R02
        nxt_drop_b = strm_b_i.is_void && !ctrl_ff[rxp_pkg::CTRL_VOID_B]; // R02
        nxt_abort = (pkt_i.crc_err && ctrl_ff[rxp_pkg::CTRL_CRC_DROP]) || // R03
            pkt_i.no_dest || pkt_i.bad_tcode; // R18 R19
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_code_o <= rxp_pkg::ACK_NONE;
            pkt_abort_o <= 1'b0;
            drop_a_o <= 1'b0;
            drop_b_o <= 1'b0;
            crc_flush_o <= 1'b1;
            sid_full_o <= 1'b0;
        end else begin
            ack_code_o <= nxt_ack;
            pkt_abort_o <= nxt_abort;
            drop_a_o <= nxt_drop_a;
            drop_b_o <= nxt_drop_b;
            crc_flush_o <= ctrl_ff[rxp_pkg::CTRL_CRC_DROP]; // R03
            sid_full_o <= ctrl_ff[rxp_pkg::CTRL_SID_FULL]; // R04
        end
    end

    // Stream status captured per packet
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            par_a_ff <= 1'b0;
            par_b_ff <= 1'b0;
            cci_a_ff <= 2'b00;
            cci_b_ff <= 2'b00;
        end else begin
            if (strm_a_i.pkt_done) begin
                par_a_ff <= strm_a_i.key_parity; // R08
                cci_a_ff <= strm_a_i.cci_seen; // R07
            end
            if (strm_b_i.pkt_done) begin
                par_b_ff <= strm_b_i.key_parity; // R08
                cci_b_ff <= strm_b_i.cci_seen; // R07
            end
        end
    end

    // Live conflict: more than one buffer of the same video type
    always_comb begin
        nxt_conflict = 1'b0;
        for (int i = 0; i < NBUF; i++) begin
            for (int j = i + 1; j < NBUF; j++) begin
                if ((buf_vid_a_i[i] && buf_vid_a_i[j]) ||
                    (buf_vid_b_i[i] && buf_vid_b_i[j])) begin
                    nxt_conflict = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            conflict_ff <= 1'b0;
        end else begin
            conflict_ff <= nxt_conflict; // R09
        end
    end

    // Event set terms
    always_comb begin
        flag_set = 32'h0000_0000;
        if (pkt_i.abort || nxt_abort) begin
            flag_set[rxp_pkg::FLG_ABORT_LSB + 32'(pkt_i.buf_idx)] = 1'b1; // R10
        end
        if (pkt_i.confirm) begin
            flag_set[rxp_pkg::FLG_ARRIVE_LSB + 32'(pkt_i.buf_idx)] = 1'b1; // R11
        end
        flag_set[rxp_pkg::FLG_PAR_B] = strm_b_i.pkt_done &&
            (strm_b_i.key_parity != par_b_ff); // R12
        flag_set[rxp_pkg::FLG_PAR_A] = strm_a_i.pkt_done &&
            (strm_a_i.key_parity != par_a_ff); // R12
        flag_set[rxp_pkg::FLG_CCI_B] = strm_b_i.pkt_done &&
            (strm_b_i.cci_seen != strm_b_i.cci_cipher); // R13
        flag_set[rxp_pkg::FLG_CCI_A] = strm_a_i.pkt_done &&
            (strm_a_i.cci_seen != strm_a_i.cci_cipher); // R13
        flag_set[rxp_pkg::FLG_STEER_B] = strm_b_i.steer_err; // R14
        flag_set[rxp_pkg::FLG_STEER_A] = strm_a_i.steer_err; // R14
        flag_set[rxp_pkg::FLG_SEQ_B] = strm_b_i.seq_err; // R15
        flag_set[rxp_pkg::FLG_SEQ_A] = strm_a_i.seq_err; // R15
        flag_set[rxp_pkg::FLG_REJECT] = nxt_ack == rxp_pkg::ACK_BUSY_X; // R16
        flag_set[rxp_pkg::FLG_CRC] = pkt_i.crc_err; // R17
        flag_set[rxp_pkg::FLG_NODEST] = pkt_i.no_dest; // R18
        flag_set[rxp_pkg::FLG_TCODE] = pkt_i.bad_tcode; // R19
        flag_set[rxp_pkg::FLG_OCCUPIED] = pkt_i.start &&
            pkt_i.engine_busy; // R20
        flag_set[rxp_pkg::FLG_RST_CMD] = pkt_i.rst_cmd; // R21
        flag_set[rxp_pkg::FLG_SID_DONE] = pkt_i.sid_done; // R22
    end

    // Read clears what it returned; a new set in the same cycle wins
    assign rd_clr = (bus_go && !hwrite_i &&
        haddr_i[11:2] == rxp_pkg::FLAG_ADDR[11:2]) ? flag_ff : 32'h0;
    assign nxt_flag = ((flag_ff & ~rd_clr) | flag_set) & rxp_pkg::FLG_VALID;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= 32'h0000_0000;
        end else begin
            flag_ff <= nxt_flag; // R24
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            summary_irq_o <= 1'b0;
        end else begin
            summary_irq_o <= |(nxt_flag & mask_ff); // R23
        end
    end
endmodule : rxp_regs
`default_nettype wire
